// File: hdl/wdk_map.svh
`ifndef WDK_MAP_SVH
`define WDK_MAP_SVH

// ---------------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------------
`define WDK_RELOAD_OFF     12'h000
`define WDK_CONTROL_OFF    12'h004
`define WDK_REFRESH_OFF    12'h008
`define WDK_COUNT_OFF      12'h00c
`define WDK_IRQ_STAT_OFF   12'h010
`define WDK_IRQ_MASK_OFF   12'h014
`define WDK_RESET_STAT_OFF 12'h018

// ---------------------------------------------------------------------------
// Control field positions and reset values
// ---------------------------------------------------------------------------
`define WDK_CTL_ON_BIT       0
`define WDK_CTL_SLEEP_BIT    2
`define WDK_CTL_WEEK_BIT     3
`define WDK_CTL_DEBUG_BIT    4
`define WDK_CTL_RESET        8'h00
`define WDK_RELOAD_RESET     16'hffff
`define WDK_COUNT_RESET      16'hffff

// ---------------------------------------------------------------------------
// Interrupt status bits
// ---------------------------------------------------------------------------
`define WDK_IRQ_EXPIRE_BIT   0
`define WDK_IRQ_REFRESH_BIT  1

// ---------------------------------------------------------------------------
// Timing: the slow tick arrives as a one-cycle pulse of the 32 kHz clock.
// ---------------------------------------------------------------------------
`define WDK_TICKS_PER_STEP   6'd33

`endif

// File: hdl/wdk_pkg.sv
package wdk_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wdk_apb_req_type;

  typedef struct packed {
    logic debug_active;
    logic week_active;
    logic sleep0_active;
  } wdk_hold_src_type;

endpackage

// File: hdl/wdk_watchdog.sv
`timescale 1ns/1ns

`include "wdk_map.svh"

module wdk_watchdog
  import wdk_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Slow time base and hold sources
  input  wire logic        TICK_32K,
  input  wire logic        DEBUG_ACTIVE,
  input  wire logic        WEEK_ACTIVE,
  input  wire logic        SLEEP0_ACTIVE,
  // Events
  output logic             EXPIRE_PULSE,
  output logic             IRQ
);

  // -------------------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------------------
  wdk_apb_req_type  req;
  wdk_hold_src_type hold_src;
  logic             access;
  logic             wr_en;
  logic             mapped;
  logic             setup;
  logic             sel_reload;
  logic             sel_control;
  logic             sel_refresh;
  logic             sel_count;
  logic             sel_irq_stat;
  logic             sel_irq_mask;
  logic             sel_reset_stat;

  assign req      = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR,
                      pwdata: PWDATA};
  assign hold_src = '{debug_active: DEBUG_ACTIVE, week_active: WEEK_ACTIVE,
                      sleep0_active: SLEEP0_ACTIVE};

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction

  // Zero-wait-state slave: PREADY is raised from the setup cycle, so it stands in
  // the first access cycle and every write lands at the edge that completes it.
  assign setup  = req.psel && !req.penable;
  assign access = req.psel && req.penable && PREADY;
  assign wr_en  = access && req.pwrite;

  // -------------------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------------------
  assign sel_reload     = hit(req.paddr, `WDK_RELOAD_OFF);
  assign sel_control    = hit(req.paddr, `WDK_CONTROL_OFF);
  assign sel_refresh    = hit(req.paddr, `WDK_REFRESH_OFF);
  assign sel_count      = hit(req.paddr, `WDK_COUNT_OFF);
  assign sel_irq_stat   = hit(req.paddr, `WDK_IRQ_STAT_OFF);
  assign sel_irq_mask   = hit(req.paddr, `WDK_IRQ_MASK_OFF);
  assign sel_reset_stat = hit(req.paddr, `WDK_RESET_STAT_OFF);
  // Unmapped offsets answer with an error, read as zero and store nothing.
  assign mapped = sel_reload || sel_control || sel_refresh || sel_count ||
                  sel_irq_stat || sel_irq_mask || sel_reset_stat;

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  logic [7:0]  control_reg;
  logic [15:0] reload_value_reg;
  logic [15:0] current_tally_reg;
  logic [5:0]  tick_cnt_reg;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_mask_reg;
  logic        reset_flag_reg;
  logic        watchdog_on;
  logic        held;
  logic        step;
  logic        underflow;
  logic        reload_wr;
  logic        refresh_wr;
  logic [1:0]  irq_set;
  logic [1:0]  irq_stat_next;
  logic [2:0]  hold_en;
  logic [2:0]  hold_bits;
  logic [2:0]  hold_hit;
  logic [15:0] tally_next;
  logic [31:0] read_next;

  assign watchdog_on = control_reg[`WDK_CTL_ON_BIT];
  assign reload_wr  = wr_en && sel_reload;
  assign refresh_wr = wr_en && sel_refresh && watchdog_on;
  assign step       = watchdog_on && !held && TICK_32K &&
                      (tick_cnt_reg == `WDK_TICKS_PER_STEP - 6'd1);
  // A reload or refresh in the cycle of the final step wins, so no expiry follows.
  assign underflow  = step && (current_tally_reg == 16'h0000) && !reload_wr && !refresh_wr;
  assign irq_set    = {refresh_wr, underflow};

  // -------------------------------------------------------------------------
  // Hold sources
  // -------------------------------------------------------------------------
  assign hold_en   = control_reg[`WDK_CTL_SLEEP_BIT +: 3];
  assign hold_bits = hold_src;
  // Bit order matches the enable field: sleep timer lowest, debug highest.
  for (genvar i = 0; i < 3; i++) begin : g_hold
    assign hold_hit[i] = hold_en[i] && hold_bits[i];
  end
  assign held = |hold_hit;

  // -------------------------------------------------------------------------
  // Control and reload registers
  // -------------------------------------------------------------------------

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      control_reg <= `WDK_CTL_RESET;
    end else if (wr_en && hit(req.paddr, `WDK_CONTROL_OFF)) begin
      // Bit 1 is a test bit that reads zero; bits 7:5 are reserved.
      control_reg <= {3'h0, req.pwdata[4:2], 1'b0, req.pwdata[0]};
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      reload_value_reg <= `WDK_RELOAD_RESET;
    end else if (reload_wr) begin
      reload_value_reg <= req.pwdata[15:0];
    end
  end

  // -------------------------------------------------------------------------
  // Prescaler
  // -------------------------------------------------------------------------
  // The prescaler only advances while counting, so a hold freezes the
  // partial tick as well and the count resumes exactly where it stopped.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tick_cnt_reg <= 6'h00;
    end else if (reload_wr || refresh_wr || !watchdog_on) begin
      tick_cnt_reg <= 6'h00;
    end else if (TICK_32K && !held) begin
      if (tick_cnt_reg == `WDK_TICKS_PER_STEP - 6'd1) begin
        tick_cnt_reg <= 6'h00;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 6'd1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Countdown
  // -------------------------------------------------------------------------
  // After an underflow the countdown restarts from the reload value and keeps
  // running, so a stuck program sees an expiry every interval, not just once.
  always_comb begin
    tally_next = current_tally_reg;
    if (reload_wr) begin
      tally_next = req.pwdata[15:0];
    end else if (refresh_wr) begin
      tally_next = reload_value_reg;
    end else if (underflow) begin
      tally_next = reload_value_reg;
    end else if (step) begin
      tally_next = current_tally_reg - 16'd1;
    end
  end

  // With no step taken the value simply stands, which is how a hold resumes.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      current_tally_reg <= `WDK_COUNT_RESET;
    end else begin
      current_tally_reg <= tally_next;
    end
  end

  // -------------------------------------------------------------------------
  // Expiry and reset status
  // -------------------------------------------------------------------------

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      EXPIRE_PULSE <= 1'b0;
    end else begin
      EXPIRE_PULSE <= underflow;
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      reset_flag_reg <= 1'b0;
    end else if (underflow) begin
      reset_flag_reg <= 1'b1;
    end else if (wr_en && hit(req.paddr, `WDK_RESET_STAT_OFF) && req.pwdata[0]) begin
      reset_flag_reg <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Interrupts
  // -------------------------------------------------------------------------
  // A new event in the same cycle as its write-one clear keeps the bit set.
  always_comb begin
    irq_stat_next = irq_stat_reg | irq_set;
    if (wr_en && sel_irq_stat) begin
      irq_stat_next = (irq_stat_reg & ~req.pwdata[1:0]) | irq_set;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq_mask_reg <= 2'h0;
    end else if (wr_en && hit(req.paddr, `WDK_IRQ_MASK_OFF)) begin
      irq_mask_reg <= req.pwdata[1:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // -------------------------------------------------------------------------
  // Read path and handshake
  // -------------------------------------------------------------------------
  // One answer per transfer: PREADY stands for exactly the first access cycle.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= setup && !mapped;
    end
  end

  // Read data is taken at the end of the setup cycle; reads have no side
  // effects, so sampling one cycle ahead of completion is harmless.
  always_comb begin
    read_next = 32'h0000_0000;
    if (setup && !req.pwrite) begin
      unique case (1'b1)
        sel_reload:     read_next = {16'h0000, reload_value_reg};
        sel_control:    read_next = {24'h000000, control_reg};
        sel_count:      read_next = {16'h0000, current_tally_reg};
        sel_irq_stat:   read_next = {30'h0, irq_stat_reg};
        sel_irq_mask:   read_next = {30'h0, irq_mask_reg};
        sel_reset_stat: read_next = {31'h0, reset_flag_reg};
        default:        read_next = 32'h0000_0000;
      endcase
    end
  end

  // Outside the answer cycle the read bus rests at zero.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else begin
      PRDATA <= read_next;
    end
  end

endmodule // wdk_watchdog

// File: verification/wdk_watchdog_checker.sv
`timescale 1ns/1ns
module wdk_watchdog_checker
  import wdk_pkg::*;
(
  // Clock, reset and bus
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  // Hold sources and event
  input wire logic        DEBUG_ACTIVE,
  input wire logic        WEEK_ACTIVE,
  input wire logic        SLEEP0_ACTIVE,
  input wire logic        EXPIRE_PULSE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  logic       take;
  logic [4:0] ctl_reg;
  logic       fresh_reg;
  assign take = PSEL && PENABLE && PREADY;
  // -----------------------------------------------------------------
  // Shadow of control writes, since the body is not visible here.
  // -----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctl_reg   <= 5'h00;
      fresh_reg <= 1'b1;
    end else if (take && PWRITE && PADDR[11:3] == 9'h000) begin
      if (PADDR == 12'h004) ctl_reg <= PWDATA[4:0];
      fresh_reg <= 1'b0;
    end
  end
  // A step and its pulse lie one edge apart, so the middle of the three held samples covers the step.
  property quiet(logic h);
    h && $past(h) && $past(h, 2) |-> !EXPIRE_PULSE;
  endproperty
  refresh_zero_a: assert property (
    take && !PWRITE && PADDR == 12'h008 |-> PRDATA == 32'h0)
    else $error("refresh read not zero");
  count_reset_a: assert property (
    take && !PWRITE && PADDR == 12'h00c && fresh_reg |-> PRDATA == 32'h0000ffff)
    else $error("count not ffff after reset");
  expire_single_a: assert property (EXPIRE_PULSE |=> !EXPIRE_PULSE)
    else $error("expiry pulse too long");
  off_quiet_a: assert property (quiet(!ctl_reg[0]))
    else $error("expiry while off");
  debug_hold_a: assert property (quiet(ctl_reg[4] && DEBUG_ACTIVE))
    else $error("expiry during debug hold");
  week_hold_a: assert property (quiet(ctl_reg[3] && WEEK_ACTIVE))
    else $error("expiry during alarm hold");
  sleep_hold_a: assert property (quiet(ctl_reg[2] && SLEEP0_ACTIVE))
    else $error("expiry during sleep hold");
  reload_guard_a: assert property (
    take && PWRITE && PADDR == 12'h000 |-> ##2 !EXPIRE_PULSE [*8])
    else $error("expiry right after reload");
  cover property (EXPIRE_PULSE);
  cover property (ctl_reg[4] && DEBUG_ACTIVE);
  cover property (take && PADDR == 12'h008);
endmodule // wdk_watchdog_checker

bind wdk_watchdog wdk_watchdog_checker chk (
  .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .DEBUG_ACTIVE(DEBUG_ACTIVE), .WEEK_ACTIVE(WEEK_ACTIVE),
  .SLEEP0_ACTIVE(SLEEP0_ACTIVE), .EXPIRE_PULSE(EXPIRE_PULSE));

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench
  import wdk_pkg::*;
;
  logic             mclk = 1'b0;
  logic             rst = 1'b1;
  logic             tick = 1'b0;
  logic [31:0]      rdata, prdata;
  logic             err, pready, pslverr, expire, irq;
  int               fail_count = 0, n_tests = 0, cyc = 0, n_exp = 0;
  wdk_apb_req_type  req = '0;
  wdk_hold_src_type src = '0;
  always #50 mclk = ~mclk;
  wdk_watchdog dut (
    .MCLK(mclk), .RST(rst), .PSEL(req.psel), .PENABLE(req.penable), .PWRITE(req.pwrite),
    .PADDR(req.paddr), .PWDATA(req.pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TICK_32K(tick), .DEBUG_ACTIVE(src.debug_active),
    .WEEK_ACTIVE(src.week_active), .SLEEP0_ACTIVE(src.sleep0_active),
    .EXPIRE_PULSE(expire), .IRQ(irq));
  // -----------------------------------------------------------------
  // Bus and compare tasks.
  // -----------------------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Waits as long as the slave takes; only the cycle ceiling ends a hang.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask
  // Exactly n tick pulses, so step counts are exact from a cleared prescaler.
  task automatic ticks(input int n);
    @(posedge mclk);
    tick <= 1'b1;
    repeat (n) @(posedge mclk);
    tick <= 1'b0;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (expire === 1'b1) n_exp++;
    if (cyc > 5000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rd(12'h004, 32'h0);
    rd(12'h000, 32'hffff);
    bus(1'b1, 12'h00c, 32'h1234);
    rd(12'h00c, 32'hffff);
    rd(12'h008, 32'h0);
    bus(1'b0, 12'h01c, 32'h0);
    check(32'(err), 32'h1);
    bus(1'b1, 12'h004, 32'hff);
    rd(12'h004, 32'h1d);
    bus(1'b1, 12'h004, 32'h0);
    bus(1'b1, 12'h000, 32'h10);
    rd(12'h00c, 32'h10);
    ticks(66);
    rd(12'h00c, 32'h10);
    bus(1'b1, 12'h004, 32'h1);
    ticks(66);
    rd(12'h00c, 32'h0e);
    ticks(32);
    rd(12'h00c, 32'h0e);
    ticks(1);
    rd(12'h00c, 32'h0d);
    bus(1'b1, 12'h008, 32'h0);
    rd(12'h00c, 32'h10);
    for (int i = 0; i < 3; i++) begin
      src <= wdk_hold_src_type'(3'(1 << i));
      bus(1'b1, 12'h004, 32'h1 | (32'h4 << i));
      ticks(40);
      rd(12'h00c, 32'h10 - i);
      bus(1'b1, 12'h004, 32'h1);
      ticks(33);
      rd(12'h00c, 32'h0f - i);
    end
    src <= '0;
    bus(1'b1, 12'h010, 32'h3);
    bus(1'b1, 12'h004, 32'h0);
    bus(1'b1, 12'h008, 32'h0);
    rd(12'h00c, 32'h0d);
    rd(12'h010, 32'h0);
    bus(1'b1, 12'h000, 32'h1);
    bus(1'b1, 12'h014, 32'h1);
    bus(1'b1, 12'h004, 32'h1);
    ticks(66);
    rd(12'h00c, 32'h1);
    check(32'(n_exp), 32'h1);
    rd(12'h018, 32'h1);
    bus(1'b1, 12'h014, 32'h0);
    rd(12'h010, 32'h1);
    check(32'(irq), 32'h0);
    bus(1'b1, 12'h014, 32'h1);
    rd(12'h010, 32'h1);
    check(32'(irq), 32'h1);
    bus(1'b1, 12'h010, 32'h1);
    rd(12'h010, 32'h0);
    check(32'(irq), 32'h0);
    conclude();
  end
endmodule // testbench
